// ===== hub_params.svh
// constants and timing figures for the hub lock sequencer
`ifndef HUB_PARAMS_SVH
`define HUB_PARAMS_SVH
`define CLK_HZ          100000000
`define CONFIRM_HOLD_MS 5000
`define LOCK_TIMEOUT_MS 15000
`define UNLOCK_PULSE_MS 10000
`define FLASH_HALF_MS   500
`define MS_TO_CYC(ms)   ((ms) * (`CLK_HZ / 1000))
`endif

// ===== hub_pkg.sv
// types shared by the hub lock sequencer modules
package hub_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_locking,
    st_confirm_hold,
    st_locked,
    st_lock_fault,
    st_unlocking
  } seq_state_e;
  typedef logic [31:0] cycle_count_t;
endpackage

// ===== hub_timer_if.sv
// carrier between sequencer and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface hub_timer_if;
  import hub_pkg::*;
  logic         start;
  cycle_count_t load;
  logic         expired;
  modport ctrl (output start, output load, input expired);
  modport tmr  (input start, input load, output expired);
endinterface
`default_nettype wire

// ===== hub_interval_timer.sv
// down counter that flags expiry of a loaded interval
`timescale 1ns/1ps
`default_nettype none
module hub_interval_timer
  import hub_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  hub_timer_if.tmr   tif
);
  cycle_count_t remaining;
  logic         running;

  // reload wins over counting so an abort restarts cleanly
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      remaining <= '0;
      running   <= 1'b0;
    end else if (tif.start) begin
      remaining <= tif.load;
      running   <= 1'b1;
    end else if (running && remaining != '0) begin
      remaining <= remaining - 32'h1;
    end else begin
      running   <= 1'b0;
    end
  end

  assign tif.expired = running && (remaining == '0) && !tif.start;
endmodule
`default_nettype wire

// ===== hub_lock_sequencer.sv
// vacuum hub lock/unlock sequencer with indicator drive
`include "hub_params.svh"
`timescale 1ns/1ps
`default_nettype none

// how the sequencer behaves, seen from the pins:
//
// the request switch is a level. Only its edges matter. A rising edge means the
// lever has left the two-wheel position and the hubs must be engaged. A falling
// edge means the lever is back in two-wheel and the hubs must be released.
//
// engaging opens the lock valve at once. The vacuum switch is then watched:
//   - once it reports threshold, the lamp goes steady and the lock valve stays
//     open for the confirm hold, then closes, and the sequencer rests in locked;
//   - if it never reports within the lock timeout, the lock valve closes and
//     the lamp flashes until the driver shifts again.
//
// releasing opens the unlock valve for a fixed pulse and puts the lamp out at
// the same edge. There is no feedback on release, so the pulse is open loop.
//
// a new switch edge always wins. Whatever sequence is running is dropped, its
// valve closes on the same edge the other sequence starts, and the shared
// interval timer is reloaded. Only one timer is needed because only one
// sequence can run at a time; the price is that a dropped sequence cannot be
// resumed, it has to be started again by a fresh edge.
//
// the two valves are never open together: each output decodes a disjoint set
// of states, so a crossing pulse cannot appear even for one cycle.
//
// every output is a flop fed from next_state, so valves and lamp move on the
// same edge as the state register and never glitch on the pins.
//
// the vacuum switch is only looked at while engaging; a stuck-on switch in any
// other state is harmless. It is sampled raw, so a bouncing switch is taken at
// its first high sample. That is the intent: the hold time that follows covers
// the settling of the hub mechanism anyway.
//
// timing: every interval runs exactly its nominal count. The timer is loaded with
// one less than the count, and the state change is taken on the edge that ends the
// cycle in which the timer reports expiry, so no extra cycle is added.
module hub_lock_sequencer #(
  parameter int unsigned CONFIRM_HOLD_CYC = `MS_TO_CYC(`CONFIRM_HOLD_MS),
  parameter int unsigned LOCK_TIMEOUT_CYC = `MS_TO_CYC(`LOCK_TIMEOUT_MS),
  parameter int unsigned UNLOCK_PULSE_CYC = `MS_TO_CYC(`UNLOCK_PULSE_MS),
  parameter int unsigned FLASH_HALF_CYC   = `MS_TO_CYC(`FLASH_HALF_MS)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          drive_request_switch,
  input  wire logic          vacuum_ok,
  output var  logic          lock_valve_drive,
  output var  logic          unlock_valve_drive,
  output var  logic          indicator,
  output var  hub_pkg::seq_state_e state
);
  import hub_pkg::*;

  // elaboration checks: a zero count would make the timer reload underflow
  if (CONFIRM_HOLD_CYC < 1) begin : g_bad_confirm
    $error("hub_lock_sequencer: confirm hold count must be at least one cycle");
  end
  if (LOCK_TIMEOUT_CYC < 1) begin : g_bad_timeout
    $error("hub_lock_sequencer: lock timeout count must be at least one cycle");
  end
  if (UNLOCK_PULSE_CYC < 1) begin : g_bad_unlock
    $error("hub_lock_sequencer: unlock pulse count must be at least one cycle");
  end
  if (FLASH_HALF_CYC < 1) begin : g_bad_flash
    $error("hub_lock_sequencer: flash half period must be at least one cycle");
  end

  hub_timer_if tif ();
  hub_interval_timer u_timer (.clk(clk), .rst(rst), .tif(tif));

  seq_state_e next_state;
  logic       switch_prev;
  logic       rise;
  logic       fall;
  cycle_count_t flash_cnt;
  logic       flash_phase;
  logic       lock_phase;
  logic       unlock_phase;
  logic       lamp_steady;
  logic       lamp_flash;

  // switch edges; any change aborts a running sequence
  assign rise = drive_request_switch && !switch_prev;
  assign fall = !drive_request_switch && switch_prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) switch_prev <= 1'b0;
    else     switch_prev <= drive_request_switch;
  end

  // sequence control; edges take priority so aborts restart at once
  always_comb begin
    next_state = state;
    tif.start  = 1'b0;
    tif.load   = '0;
    if (rise) begin
      next_state = st_locking;
      tif.start  = 1'b1;
      tif.load   = cycle_count_t'(LOCK_TIMEOUT_CYC - 1);
    end else if (fall) begin
      next_state = st_unlocking;
      tif.start  = 1'b1;
      tif.load   = cycle_count_t'(UNLOCK_PULSE_CYC - 1);
    end else begin
      case (state)
        st_locking: begin
          if (vacuum_ok) begin
            next_state = st_confirm_hold;
            tif.start  = 1'b1;
            tif.load   = cycle_count_t'(CONFIRM_HOLD_CYC - 1);
          end else if (tif.expired) begin
            next_state = st_lock_fault;
          end
        end
        st_confirm_hold: if (tif.expired) next_state = st_locked;
        st_unlocking:    if (tif.expired) next_state = st_idle;
        st_idle, st_locked, st_lock_fault: next_state = state;
        default:         next_state = st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) state <= st_idle;
    else     state <= next_state;
  end

  // flash timebase only runs in fault so the lamp starts lit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_cnt   <= '0;
      flash_phase <= 1'b1;
    end else if (next_state != st_lock_fault) begin
      flash_cnt   <= '0;
      flash_phase <= 1'b1;
    end else if (flash_cnt == cycle_count_t'(FLASH_HALF_CYC - 1)) begin
      flash_cnt   <= '0;
      flash_phase <= !flash_phase;
    end else begin
      flash_cnt   <= flash_cnt + 32'h1;
    end
  end

  // output decode from the coming state; the valve sets are disjoint so
  // the two valves can never be open in the same cycle
  assign lock_phase   = (next_state == st_locking) || (next_state == st_confirm_hold);
  assign unlock_phase = (next_state == st_unlocking);
  assign lamp_steady  = (next_state == st_confirm_hold) || (next_state == st_locked);
  assign lamp_flash   = (next_state == st_lock_fault);

  // lock valve: engages the hubs only; closes on timeout, abort or end of hold
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lock_valve_drive <= 1'b0;
    else     lock_valve_drive <= lock_phase;
  end

  // unlock valve: releases the hubs only, for the fixed pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) unlock_valve_drive <= 1'b0;
    else     unlock_valve_drive <= unlock_phase;
  end

  // lamp: steady in confirm hold and locked, flashing on fault, dark otherwise; it goes out
  // on the same edge that starts the unlock pulse
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      indicator <= 1'b0;
    end else if (lamp_steady) begin
      indicator <= 1'b1;
    end else if (lamp_flash) begin
      indicator <= flash_phase;
    end else begin
      indicator <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hub_lock_sequencer_props.sv
// port assertions for the hub lock sequencer
`timescale 1ns/1ps
`default_nettype none
module hub_lock_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic drive_request_switch,
  input wire logic vacuum_ok,
  input wire logic lock_valve_drive,
  input wire logic unlock_valve_drive,
  input wire logic indicator,
  input wire hub_pkg::seq_state_e state
);
  import hub_pkg::*;
  wire logic sw = drive_request_switch;
  wire logic lk = lock_valve_drive;
  // cycle figures assume the shortened counts the bench builds with
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_dark; (state == st_lock_fault && $stable(indicator)) [*4]; endsequence
  property p_req; $rose(sw) |=> state == st_locking; endproperty
  a_req: assert property (p_req) else $error("request");
  property p_excl; !(lk && unlock_valve_drive); endproperty
  a_excl: assert property (p_excl) else $error("both valves");
  property p_lock; $rose(sw) |=> lk && !unlock_valve_drive; endproperty
  a_lock: assert property (p_lock) else $error("lock start");
  property p_hold; state == st_confirm_hold |-> ##[1:7] state != st_confirm_hold; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_flash; not s_dark; endproperty
  a_flash: assert property (p_flash) else $error("no flash");
  property p_drop; $fell(sw) |=> unlock_valve_drive && !indicator && !lk; endproperty
  a_drop: assert property (p_drop) else $error("unlock");
  property p_lit; state inside {st_confirm_hold, st_locked} |-> indicator; endproperty
  a_lit: assert property (p_lit) else $error("lamp");
  property p_abort; state == st_unlocking && $rose(sw) |=> state == st_locking; endproperty
  a_abort: assert property (p_abort) else $error("abort");
endmodule
bind hub_lock_sequencer hub_lock_props hub_lock_props_inst (.*);
`default_nettype wire

// ===== hub_vacuum_model.sv
// vacuum circuit stand-in: pressure builds while the lock valve is open
`timescale 1ns/1ps
`default_nettype none
module hub_vacuum_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       lock_valve_drive,
  input  wire logic       leak,
  input  wire logic [3:0] delay,
  output var  logic       vacuum_ok
);
  logic [3:0] fill;
  // saturating fill count; a leak keeps the switch off so timeouts happen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) fill <= 4'h0;
    else if (!lock_valve_drive) fill <= 4'h0;
    else if (fill != 4'hF) fill <= fill + 4'h1;
  end
  assign vacuum_ok = !leak && lock_valve_drive && fill >= delay;
endmodule
`default_nettype wire

// ===== tb_hub_lock_sequencer.sv
// self-checking bench for the hub lock sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb_hub_lock_sequencer;
  import hub_pkg::*;
  logic clk = 0, rst = 1, sw = 0, leak = 0, lk, ul, lamp, vac;
  logic [3:0] dly = 4'h1;
  seq_state_e st;
  int bad_count = 0, comparisons = 0, n;
  always #5 clk = ~clk;
  hub_lock_sequencer #(.CONFIRM_HOLD_CYC(5), .LOCK_TIMEOUT_CYC(15), .UNLOCK_PULSE_CYC(10), .FLASH_HALF_CYC(2))
    hub_lock_sequencer_inst (.clk(clk), .rst(rst), .drive_request_switch(sw), .vacuum_ok(vac),
    .lock_valve_drive(lk), .unlock_valve_drive(ul), .indicator(lamp), .state(st));
  hub_vacuum_model hub_vacuum_model_inst (.clk(clk), .rst(rst), .lock_valve_drive(lk), .leak(leak),
    .delay(dly), .vacuum_ok(vac));
  // one cycle of slack on each interval is allowed
  function logic near(int got, int want); return got >= want && got <= want + 1; endfunction
  // lamp in fault starts lit and toggles every two cycles at the bench's flash count
  function logic flash_exp(int j); return ((j / 2) % 2) == 0; endfunction
  task step(int k); repeat (k) @(posedge clk); #1; endtask
  task report_and_stop; begin
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  end endtask
  // bounded: a valve stuck on ends the run
  task hold(bit u); begin
    n = 0;
    while ((u ? ul : lk) && n < 40) begin step(1); n++; end
    if (n == 40) begin bad_count++; report_and_stop; end
  end endtask
  initial begin
    void'($urandom(25904));
    step(3); rst = 0;
    for (int i = 0; i < 3; i++) begin
      dly = 4'($urandom_range(1, 9)); sw = 1; step(1);
      `CHK(lk, 1'b1)
      hold(0);
      `CHK(n >= 5 && n <= dly + 8, 1'b1)
      `CHK(st, st_locked)
      `CHK(lamp, 1'b1)
      sw = 0; step(1);
      `CHK(lamp, 1'b0)
      hold(1);
      `CHK(near(n, 9), 1'b1)
      $display("lock and unlock pass %0d done", i);
    end
    leak = 1; sw = 1; step(1); hold(0);
    `CHK(near(n, 14), 1'b1)
    `CHK(st, st_lock_fault)
    for (int j = 0; j < 8; j++) begin
      `CHK(lamp, flash_exp(j))
      step(1);
    end
    step(1);
    leak = 0; sw = 0; step(4); sw = 1; step(1);
    `CHK({lk, ul}, 2'h2)
    $display("leak and abort done");
    repeat (30) begin sw = 1'($urandom); leak = 1'($urandom); step($urandom_range(1, 25)); end
    $display("random toggling done");
    report_and_stop;
  end
endmodule
`default_nettype wire
